// ---- prt_defs.svh ----
// prt_defs.svh: offsets, field positions, reset values and counts for the port block.
// assumes it is included by bare name from every file that needs a constant.
`ifndef PRT_DEFS_SVH
`define PRT_DEFS_SVH

// ---------------------------------------------------------------
// special function register addresses
// ---------------------------------------------------------------
`define PRT_ADDR_PORT0_LATCH   8'h80
`define PRT_ADDR_PORT1_LATCH   8'h90
`define PRT_ADDR_PORT0_DRIVE   8'ha4
`define PRT_ADDR_PORT1_DRIVE   8'ha5
`define PRT_ADDR_PORT0_KIND    8'hf1
`define PRT_ADDR_PORT1_KIND    8'hf2
`define PRT_ADDR_PORT0_MASK    8'hc1
`define PRT_ADDR_PORT0_VALUE   8'hc2
`define PRT_ADDR_PORT1_MASK    8'hc3
`define PRT_ADDR_PORT1_VALUE   8'hc4
`define PRT_ADDR_CTRL          8'hc5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PRT_RST_LATCH          8'hff
`define PRT_RST_DRIVE          8'h00
`define PRT_RST_KIND           8'hff
`define PRT_RST_MASK           8'h00
`define PRT_RST_VALUE          8'h00
`define PRT_RST_CTRL           3'h0
`define PRT_RST_RDATA          8'h00

// ---------------------------------------------------------------
// control register fields and counts
// ---------------------------------------------------------------
`define PRT_CTRL_ROUTE_EN_BIT  0
`define PRT_CTRL_PULL_OFF_BIT  1
`define PRT_CTRL_IRQ_EN_BIT    2
`define PRT_SYNC_STAGES        2
`define PRT_PORT_WIDTH         8

`endif

// ---- prt_pkg.sv ----
// prt_pkg.sv: types shared by the port block files.
// assumes prt_defs.svh supplies the numeric constants.
package prt_pkg;

  // one access from the processor special function register space
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       rmw;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prt_sfr_req_t;

  // global control bits, msb first
  typedef struct packed {
    logic irq_en;
    logic pull_off;
    logic route_en;
  } prt_ctrl_t;

endpackage

// ---- prt_sync.sv ----
// prt_sync.sv: multi-stage synchroniser, one chain per bit.
// assumes inputs may change at any time relative to core_clk_in.
`timescale 1ns/10ps
`include "prt_defs.svh"
module prt_sync
  import prt_pkg::*;
#(
  parameter int W      = 16,
  parameter int STAGES = `PRT_SYNC_STAGES
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] chain [STAGES];

  // refused at elaboration: one flop alone leaves metastability on the output
  if (STAGES < 2) begin : g_bad_stages
    $error("prt_sync needs at least two stages");
  end

  // first stage is read only by the second
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int s = 0; s < STAGES; s++) chain[s] <= '0;
    end else begin
      chain[0] <= async_in;
      for (int s = 1; s < STAGES; s++) chain[s] <= chain[s-1];
    end
  end

  assign sync_out = chain[STAGES-1];

endmodule

// ---- prt_pad.sv ----
// prt_pad.sv: per-pin output driver, enable and weak pull-up control, registered.
// assumes the pad cell drives pin_drive_out while pin_oe_n_out is low.
`timescale 1ns/10ps
`include "prt_defs.svh"
module prt_pad
  import prt_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // configuration
  input  wire logic [W-1:0] latch_in,
  input  wire logic [W-1:0] push_pull_in,
  input  wire logic [W-1:0] digital_in,
  input  wire logic [W-1:0] claim_in,
  input  wire logic [W-1:0] periph_in,
  input  wire prt_ctrl_t    ctrl_in,
  // pad controls
  output logic      [W-1:0] pin_drive_out,
  output logic      [W-1:0] pin_oe_n_out,
  output logic      [W-1:0] pin_pullup_out
);

  logic [W-1:0] val;
  logic [W-1:0] drv_en;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  for (genvar i = 0; i < W; i++) begin : g_pin
    assign val[i]    = claim_in[i] ? periph_in[i] : latch_in[i];
    // open-drain high releases the pin; analogue pins never drive
    assign drv_en[i] = ctrl_in.route_en & digital_in[i]
                       & (push_pull_in[i] | ~val[i]);

    always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
        pin_drive_out[i]  <= 1'b0;
        pin_oe_n_out[i]   <= 1'b1;
        pin_pullup_out[i] <= 1'b0;
      end else begin
        pin_drive_out[i]  <= val[i];
        pin_oe_n_out[i]   <= ~drv_en[i];
        pin_pullup_out[i] <= ~ctrl_in.pull_off & digital_in[i] & ~push_pull_in[i]
                             & ~(drv_en[i] & ~val[i]);
      end
    end
  end

  property p_no_drive_unrouted;
    !$past(ctrl_in.route_en) |-> (&pin_oe_n_out);
  endproperty
  a_no_drive_unrouted: assert property (p_no_drive_unrouted)
    else $error("pin driven while routing disabled");

  property p_od_release;
    ((pin_oe_n_out | $past(~val | push_pull_in)) == {W{1'b1}});
  endproperty
  a_od_release: assert property (p_od_release)
    else $error("open-drain pin driven high");

  property p_analog_quiet;
    ((pin_oe_n_out & ~pin_pullup_out) | $past(digital_in)) == {W{1'b1}};
  endproperty
  a_analog_quiet: assert property (p_analog_quiet)
    else $error("analogue pin has driver or pull-up on");

endmodule

// ---- prt_port_io.sv ----
// prt_port_io.sv: two 8-bit general-purpose ports with latches, pin reads and match detect.
// assumes the processor presents one register access per cycle on sfr_req_in,
// and that the crossbar supplies per-pin claim and peripheral drive levels.
//
// Contract
// - pins not claimed by a peripheral or analogue use act as general-purpose pins
// - port registers accessible as whole byte and as single bits
// - port write stores value in a latch that holds until next write
// - latch bit reaches pin only when crossbar leaves pin as port output
// - plain port read returns live pin levels, even for claimed pins
// - read-modify-write accesses read the latch, not the pins
// - pin set as analogue input always reads 0
// - latch 1 with open-drain mode releases the pin instead of driving
// - port 0 latch resets to all ones
// - port 0 register sits at address 0x80 and is bit addressable
// - port 0 match event when masked pins differ from masked compare value
// - port 1 match event when masked pins differ from masked compare value
// - match compares pin levels regardless of crossbar assignments
// - match raises interrupt request only while match interrupt enable is 1
// - match event wakes suspended oscillator regardless of interrupt enable
// - wake resumes clocking independently of whether an interrupt is raised
// - input kind 1 is digital, 0 analogue with pull-up, driver, receiver off
// - with pull-ups enabled, open-drain pins get weak pull-up unless low or analogue
// - all output drivers stay off until routing is enabled
`timescale 1ns/10ps
`include "prt_defs.svh"
module prt_port_io
  import prt_pkg::*;
#(
  parameter int PORT_W      = `PRT_PORT_WIDTH,
  parameter int SYNC_STAGES = `PRT_SYNC_STAGES
) (
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  // register access
  input  wire prt_sfr_req_t        sfr_req_in,
  output logic [7:0]               sfr_rdata_out,
  // crossbar
  input  wire logic [2*PORT_W-1:0] periph_claim_in,
  input  wire logic [2*PORT_W-1:0] periph_drive_in,
  // pins
  input  wire logic [2*PORT_W-1:0] pin_level_in,
  output logic      [2*PORT_W-1:0] pin_drive_out,
  output logic      [2*PORT_W-1:0] pin_oe_n_out,
  output logic      [2*PORT_W-1:0] pin_pullup_out,
  // events
  output logic                     match_evt_out,
  output logic                     match_irq_out,
  output logic                     osc_wake_out
);

  localparam int PW = 2 * PORT_W;

  if (PORT_W != 8) begin : g_bad_width
    $error("prt_port_io serves 8-bit ports only");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("prt_port_io needs two or more sync stages");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] latch0;
  logic [7:0] latch1;
  logic [7:0] drive0;
  logic [7:0] drive1;
  logic [7:0] kind0;
  logic [7:0] kind1;
  logic [7:0] mask0;
  logic [7:0] value0;
  logic [7:0] mask1;
  logic [7:0] value1;
  prt_ctrl_t  ctrl;

  logic [PW-1:0] lvl;
  logic [7:0]    dig0;
  logic [7:0]    dig1;
  logic          hit0;
  logic          hit1;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // only the two port registers accept single-bit writes
  function automatic logic wr_hit(input prt_sfr_req_t r, input logic [7:0] a,
                                  input logic bit_ok);
    return r.wr & (r.addr == a) & (~r.bit_op | bit_ok);
  endfunction

  function automatic logic [7:0] apply(input logic [7:0] old,
                                       input prt_sfr_req_t r);
    logic [7:0] v;
    v = old;
    if (r.bit_op) begin
      v[r.bit_sel] = r.wdata[0];
    end else begin
      v = r.wdata;
    end
    return v;
  endfunction

  logic w_latch0;
  logic w_latch1;
  logic w_drive0;
  logic w_drive1;
  logic w_kind0;
  logic w_kind1;
  logic w_mask0;
  logic w_value0;
  logic w_mask1;
  logic w_value1;
  logic w_ctrl;

  assign w_latch0 = wr_hit(sfr_req_in, `PRT_ADDR_PORT0_LATCH, 1'b1);
  assign w_latch1 = wr_hit(sfr_req_in, `PRT_ADDR_PORT1_LATCH, 1'b1);
  assign w_drive0 = wr_hit(sfr_req_in, `PRT_ADDR_PORT0_DRIVE, 1'b0);
  assign w_drive1 = wr_hit(sfr_req_in, `PRT_ADDR_PORT1_DRIVE, 1'b0);
  assign w_kind0  = wr_hit(sfr_req_in, `PRT_ADDR_PORT0_KIND, 1'b0);
  assign w_kind1  = wr_hit(sfr_req_in, `PRT_ADDR_PORT1_KIND, 1'b0);
  assign w_mask0  = wr_hit(sfr_req_in, `PRT_ADDR_PORT0_MASK, 1'b0);
  assign w_value0 = wr_hit(sfr_req_in, `PRT_ADDR_PORT0_VALUE, 1'b0);
  assign w_mask1  = wr_hit(sfr_req_in, `PRT_ADDR_PORT1_MASK, 1'b0);
  assign w_value1 = wr_hit(sfr_req_in, `PRT_ADDR_PORT1_VALUE, 1'b0);
  assign w_ctrl   = wr_hit(sfr_req_in, `PRT_ADDR_CTRL, 1'b0);

  // ---------------------------------------------------------------
  // output latches
  // ---------------------------------------------------------------
  // a bit write modifies the latch copy, never the pin levels
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      latch0 <= `PRT_RST_LATCH;
      latch1 <= `PRT_RST_LATCH;
    end else begin
      if (w_latch0) latch0 <= apply(latch0, sfr_req_in);
      if (w_latch1) latch1 <= apply(latch1, sfr_req_in);
    end
  end

  // ---------------------------------------------------------------
  // pin mode registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      drive0 <= `PRT_RST_DRIVE;
      drive1 <= `PRT_RST_DRIVE;
      kind0  <= `PRT_RST_KIND;
      kind1  <= `PRT_RST_KIND;
    end else begin
      if (w_drive0) drive0 <= sfr_req_in.wdata;
      if (w_drive1) drive1 <= sfr_req_in.wdata;
      if (w_kind0)  kind0  <= sfr_req_in.wdata;
      if (w_kind1)  kind1  <= sfr_req_in.wdata;
    end
  end

  // ---------------------------------------------------------------
  // match and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mask0  <= `PRT_RST_MASK;
      value0 <= `PRT_RST_VALUE;
      mask1  <= `PRT_RST_MASK;
      value1 <= `PRT_RST_VALUE;
      ctrl   <= `PRT_RST_CTRL;
    end else begin
      if (w_mask0)  mask0  <= sfr_req_in.wdata;
      if (w_value0) value0 <= sfr_req_in.wdata;
      if (w_mask1)  mask1  <= sfr_req_in.wdata;
      if (w_value1) value1 <= sfr_req_in.wdata;
      if (w_ctrl) begin
        ctrl.route_en <= sfr_req_in.wdata[`PRT_CTRL_ROUTE_EN_BIT];
        ctrl.pull_off <= sfr_req_in.wdata[`PRT_CTRL_PULL_OFF_BIT];
        ctrl.irq_en   <= sfr_req_in.wdata[`PRT_CTRL_IRQ_EN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // pin input path
  // ---------------------------------------------------------------
  prt_sync #(
    .W      (PW),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    (pin_level_in),
    .sync_out    (lvl)
  );

  // analogue pins have their receiver off, so they read low
  assign dig0 = lvl[7:0] & kind0;
  assign dig1 = lvl[15:8] & kind1;

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [7:0] rd_src;
  logic [7:0] next_rdata;

  always_comb begin
    case (sfr_req_in.addr)
      // read-modify-write takes the latch so claimed or loaded pins
      // cannot corrupt the written-back value
      `PRT_ADDR_PORT0_LATCH: rd_src = sfr_req_in.rmw ? latch0 : dig0;
      `PRT_ADDR_PORT1_LATCH: rd_src = sfr_req_in.rmw ? latch1 : dig1;
      `PRT_ADDR_PORT0_DRIVE: rd_src = drive0;
      `PRT_ADDR_PORT1_DRIVE: rd_src = drive1;
      `PRT_ADDR_PORT0_KIND:  rd_src = kind0;
      `PRT_ADDR_PORT1_KIND:  rd_src = kind1;
      `PRT_ADDR_PORT0_MASK:  rd_src = mask0;
      `PRT_ADDR_PORT0_VALUE: rd_src = value0;
      `PRT_ADDR_PORT1_MASK:  rd_src = mask1;
      `PRT_ADDR_PORT1_VALUE: rd_src = value1;
      `PRT_ADDR_CTRL:        rd_src = {5'h00, ctrl};
      default:               rd_src = 8'h00;
    endcase
    if (sfr_req_in.bit_op) begin
      next_rdata = {7'h00, rd_src[sfr_req_in.bit_sel]};
    end else begin
      next_rdata = rd_src;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sfr_rdata_out <= `PRT_RST_RDATA;
    end else if (sfr_req_in.rd) begin
      sfr_rdata_out <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // match detection
  // ---------------------------------------------------------------
  // compared on pin levels whatever the crossbar owns
  assign hit0 = (dig0 & mask0) != (value0 & mask0);
  assign hit1 = (dig1 & mask1) != (value1 & mask1);

  // level, not pulse: stays while the mismatch stays
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      match_evt_out <= 1'b0;
      match_irq_out <= 1'b0;
      osc_wake_out  <= 1'b0;
    end else begin
      match_evt_out <= hit0 | hit1;
      match_irq_out <= (hit0 | hit1) & ctrl.irq_en;
      osc_wake_out  <= hit0 | hit1;
    end
  end

  // ---------------------------------------------------------------
  // pad control
  // ---------------------------------------------------------------
  prt_pad #(
    .W (PW)
  ) u_pad (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .latch_in       ({latch1, latch0}),
    .push_pull_in   ({drive1, drive0}),
    .digital_in     ({kind1, kind0}),
    .claim_in       (periph_claim_in),
    .periph_in      (periph_drive_in),
    .ctrl_in        (ctrl),
    .pin_drive_out  (pin_drive_out),
    .pin_oe_n_out   (pin_oe_n_out),
    .pin_pullup_out (pin_pullup_out)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_irq_gate;
    match_irq_out == (match_evt_out && $past(ctrl.irq_en));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("match interrupt not gated by enable");

  property p_wake;
    osc_wake_out == match_evt_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake does not follow match event");

  property p_match0;
    ((dig0 & mask0) != (value0 & mask0)) |=> match_evt_out;
  endproperty
  a_match0: assert property (p_match0)
    else $error("port 0 mismatch gave no match event");

  property p_match1;
    ((dig1 & mask1) != (value1 & mask1)) |=> match_evt_out;
  endproperty
  a_match1: assert property (p_match1)
    else $error("port 1 mismatch gave no match event");

  property p_reset_latch;
    $past(rst_in) |-> (latch0 == `PRT_RST_LATCH);
  endproperty
  a_reset_latch: assert property (p_reset_latch)
    else $error("port 0 latch not all ones after reset");

  property p_latch_hold;
    !w_latch0 |=> $stable(latch0);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("port 0 latch changed without a write");

  property p_rmw_latch;
    (sfr_req_in.rd && sfr_req_in.rmw && !sfr_req_in.bit_op
     && sfr_req_in.addr == `PRT_ADDR_PORT0_LATCH) |=> (sfr_rdata_out == $past(latch0));
  endproperty
  a_rmw_latch: assert property (p_rmw_latch)
    else $error("read-modify-write did not return the latch");

  property p_pin_read;
    (sfr_req_in.rd && !sfr_req_in.rmw && !sfr_req_in.bit_op
     && sfr_req_in.addr == `PRT_ADDR_PORT0_LATCH)
    |=> (sfr_rdata_out == $past(lvl[7:0] & kind0));
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("port 0 read did not return gated pin levels");

  // wake must not depend on the interrupt enable
  property p_wake_alone;
    ((hit0 || hit1) && !ctrl.irq_en) |=> (osc_wake_out && !match_irq_out);
  endproperty
  a_wake_alone: assert property (p_wake_alone)
    else $error("match without enable did not wake on its own");

  // a bit write may only touch the selected latch bit
  property p_bit_write;
    (w_latch0 && sfr_req_in.bit_op)
    |=> (((latch0 ^ $past(latch0)) & ~(8'h01 << $past(sfr_req_in.bit_sel))) == 8'h00);
  endproperty
  a_bit_write: assert property (p_bit_write)
    else $error("bit write changed other latch bits");

endmodule

// ---- prt_board.sv ----
// prt_board.sv: board-side model of the sixteen port pins.
// assumes the port block's pad controls and a testbench that may drive pins weakly.
`timescale 1ns/10ps
module prt_board (
  // clock
  input  wire logic        core_clk_in,
  // pad controls from the port block
  input  wire logic [15:0] pin_drive_in,
  input  wire logic [15:0] pin_oe_n_in,
  input  wire logic [15:0] pin_pullup_in,
  // board stimulus
  input  wire logic [15:0] ext_en_in,
  input  wire logic [15:0] ext_val_in,
  // resolved pin levels
  output logic      [15:0] pin_level_out
);
  logic [15:0] last_level;

  always_ff @(posedge core_clk_in) begin
    last_level <= pin_level_out;
  end

  // a pin nobody drives and nothing pulls shows the inverse of its last level,
  // so a floating pin can never pass for a steady value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pin_oe_n_in[i]) begin
        pin_level_out[i] = pin_drive_in[i];
      end else if (ext_en_in[i]) begin
        pin_level_out[i] = ext_val_in[i];
      end else if (pin_pullup_in[i]) begin
        pin_level_out[i] = 1'b1;
      end else begin
        pin_level_out[i] = ~last_level[i];
      end
    end
  end
endmodule

// ---- prt_tb.sv ----
// prt_tb.sv: self-checking testbench for the two-port block.
// assumes prt_port_io with a board model on its pins; inputs change on the falling edge.
`timescale 1ns/10ps
module testbench;
  import prt_pkg::*;
  logic         core_clk_in;
  logic         rst_in;
  prt_sfr_req_t req;
  logic [7:0]   rdata;
  logic [7:0]   r;
  logic [15:0]  claim;
  logic [15:0]  pdrv;
  logic [15:0]  ext_en;
  logic [15:0]  ext_val;
  logic [15:0]  lvl;
  logic [15:0]  drv;
  logic [15:0]  oe_n;
  logic [15:0]  pu;
  logic         evt;
  logic         irq;
  logic         wake;
  int           error_cnt;
  int           cmp_count;

  prt_port_io i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
    .periph_claim_in(claim), .periph_drive_in(pdrv), .pin_level_in(lvl),
    .pin_drive_out(drv), .pin_oe_n_out(oe_n), .pin_pullup_out(pu),
    .match_evt_out(evt), .match_irq_out(irq), .osc_wake_out(wake)
  );

  prt_board i_board (
    .core_clk_in(core_clk_in), .pin_drive_in(drv), .pin_oe_n_in(oe_n),
    .pin_pullup_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_level_out(lvl)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
                    input logic [2:0] s = 3'h0);
    @(negedge core_clk_in);
    req = '0;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    req.bit_op = b;
    req.bit_sel = s;
    @(negedge core_clk_in);
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic m, input logic b = 1'b0,
                    input logic [2:0] s = 3'h0);
    @(negedge core_clk_in);
    req = '0;
    req.rd = 1'b1;
    req.rmw = m;
    req.addr = a;
    req.bit_op = b;
    req.bit_sel = s;
    @(negedge core_clk_in);
    req = '0;
    r = rdata;
  endtask

  // covers register, pad and two-stage sync latency, four cycles with none to spare
  task automatic settle;
    repeat (4) @(negedge core_clk_in);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(8'h80, 1'b1); chk(r, 8'hff);
    rd(8'h90, 1'b1); chk(r, 8'hff);
    rd(8'ha4, 1'b0); chk(r, 8'h00);
    rd(8'h3b, 1'b0); chk(r, 8'h00);
    rd(8'h80, 1'b0); chk(r, 8'hff);
    chk(oe_n, 16'hffff);
    chk(pu, 16'hffff);
    chk(16'({irq, wake, evt}), 16'h0);
  endtask

  task automatic t_latch;
    wr(8'h80, 8'h5a);
    rd(8'h80, 1'b1); chk(r, 8'h5a);
    settle;
    chk(oe_n, 16'hffff);
    wr(8'hc5, 8'h01);
    wr(8'ha4, 8'hff);
    settle;
    chk(drv[7:0], 8'h5a);
    chk(oe_n[7:0], 8'h00);
    rd(8'h80, 1'b0); chk(r, 8'h5a);
    wr(8'ha4, 8'h00);
    settle;
    chk(oe_n[7:0], 8'h5a);
    chk(pu[7:0], 8'h5a);
    wr(8'hc5, 8'h03);
    settle;
    chk(pu, 16'h0000);
    wr(8'hc5, 8'h01);
  endtask

  task automatic t_pins_vs_latch;
    ext_en[1] = 1'b1;
    ext_val[1] = 1'b0;
    claim[2] = 1'b1;
    pdrv[2] = 1'b1;
    settle;
    chk(oe_n[2], 1'b1);
    chk(drv[2], 1'b1);
    rd(8'h80, 1'b0); chk(r, 8'h5c);
    rd(8'h80, 1'b1); chk(r, 8'h5a);
    ext_en = '0;
    claim = '0;
    pdrv = '0;
  endtask

  task automatic t_bits;
    wr(8'h80, 8'h01, 1'b1, 3'h0);
    rd(8'h80, 1'b1, 1'b1, 3'h0); chk(r, 8'h01);
    rd(8'h80, 1'b1, 1'b1, 3'h2); chk(r, 8'h00);
    wr(8'h80, 8'h00, 1'b1, 3'h3);
    rd(8'h80, 1'b1); chk(r, 8'h53);
    wr(8'h90, 8'h00, 1'b1, 3'h7);
    rd(8'h90, 1'b1); chk(r, 8'h7f);
    wr(8'ha4, 8'h01, 1'b1, 3'h0);
    rd(8'ha4, 1'b0); chk(r, 8'h00);
  endtask

  task automatic t_analogue;
    wr(8'hf1, 8'hfe);
    settle;
    chk({oe_n[0], pu[0]}, 2'b10);
    rd(8'h80, 1'b0); chk(r, 8'h52);
    wr(8'hf1, 8'hff);
    chk(drv[15:8], 8'h7f);
    chk(oe_n[15:8], 8'h7f);
    wr(8'ha5, 8'hff);
    wr(8'hf2, 8'hfe);
    settle;
    chk(oe_n[15:8], 8'h01);
    chk(pu[15:8], 8'h00);
    rd(8'h90, 1'b0); chk(r, 8'h7e);
    wr(8'ha5, 8'h00);
    wr(8'hf2, 8'hff);
  endtask

  // second reset in mid-run: latch and match state must come back clean
  task automatic t_mid_reset;
    @(negedge core_clk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'b0;
    settle;
    rd(8'h80, 1'b1); chk(r, 8'hff);
    chk(16'({irq, wake, evt}), 16'h0);
  endtask

  task automatic t_match;
    wr(8'hc1, 8'h01);
    settle;
    chk(16'({irq, wake, evt}), 16'h3);
    wr(8'hc5, 8'h05);
    settle;
    chk(16'({irq, wake, evt}), 16'h7);
    wr(8'hc2, 8'h01);
    settle;
    chk(16'({irq, wake, evt}), 16'h0);
    wr(8'hc3, 8'h80);
    wr(8'hc4, 8'h80);
    settle;
    chk(16'({irq, wake, evt}), 16'h7);
    claim[15] = 1'b1;
    pdrv[15] = 1'b1;
    settle;
    chk(16'({irq, wake, evt}), 16'h0);
    wr(8'hc5, 8'h01);
    claim = '0;
    pdrv = '0;
    settle;
    chk(16'({irq, wake, evt}), 16'h3);
    rd(8'hc5, 1'b0); chk(r, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // verdict, clock, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #50us;
    error_cnt++;
    report_and_stop;
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst_in = 1'b1;
    req = '0;
    claim = '0;
    pdrv = '0;
    ext_en = '0;
    ext_val = '0;
    repeat (16) @(negedge core_clk_in);
    rst_in = 1'b0;
    settle;
    t_reset;
    t_latch;
    t_pins_vs_latch;
    t_bits;
    t_analogue;
    t_match;
    t_mid_reset;
    report_and_stop;
  end
endmodule
